// >>> logic/dts_converter_ctrl.sv
// Parallel bus front end, control and DAC registers, and result latches
module dts_converter_ctrl
    import dts_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [2:0] func_addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    output logic busy_n,
    output logic osc_en,
    output logic th_hold,
    output logic adc_side_b,
    output dts_chan_t adc_chan,
    output logic adc_range_half,
    output logic adc_active,
    input wire logic [7:0] adc_code,
    output logic [3:0] input_range_half,
    output logic [DAC_A_W-1:0] dac_a_code,
    output logic [7:0] dac_b_code,
    output logic [7:0] dac_c_code
);
    // ------------------------------------------------------------
    // Local state
    // ------------------------------------------------------------
    dts_seq_if sq ();

    logic wr_n_q;
    logic wr_sel_q;
    logic [2:0] wr_addr_q;
    logic [7:0] wr_data_q;
    logic wr_rise;
    logic [CTL_W-1:0] ctl_q;
    logic [7:0] dac_a_hi_q;
    logic [7:0] latch_a_q;
    logic [7:0] latch_b_q;
    logic start_q;
    dts_chan_t chan_q;

    // Range bit for one input; bias conversions have no selectable range
    function automatic logic range_of(input logic [CTL_W-1:0] ctl, input logic side_b,
                                      input dts_chan_t ch);
        logic r;
        r = 1'b0;
        if (ch == DTS_CH_IN1)
            r = side_b ? ctl[2] : ctl[0];
        else if (ch == DTS_CH_IN2)
            r = side_b ? ctl[3] : ctl[1];
        return r;
    endfunction : range_of

    // Start write code to converted signal
    function automatic dts_chan_t chan_of(input logic [2:0] fn);
        dts_chan_t c;
        c = DTS_CH_IN1;
        if (fn == FN_START_IN2)
            c = DTS_CH_IN2;
        else if (fn == FN_START_BIAS)
            c = DTS_CH_BIAS;
        return c;
    endfunction : chan_of

    // ------------------------------------------------------------
    // Write strobe capture
    // ------------------------------------------------------------
    // Address and data are held from the low phase of the strobe, so a
    // bus that changes right at the rising edge still writes what it meant.
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            wr_n_q <= 1'b1;
            wr_sel_q <= 1'b0;
            wr_addr_q <= 3'h0;
            wr_data_q <= 8'h00;
        end
        else
        begin
            wr_n_q <= wr_n;
            if (!wr_n)
            begin
                wr_sel_q <= !cs_n && rd_n;
                wr_addr_q <= func_addr;
                wr_data_q <= data_in;
            end
        end
    end

    // Only the low-to-high strobe transition writes anything
    assign wr_rise = !wr_n_q && wr_n && wr_sel_q;

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            ctl_q <= CTL_RESET;
        else if (wr_rise && wr_addr_q == FN_CONTROL)
            ctl_q <= wr_data_q[CTL_W-1:0];
    end

    // ------------------------------------------------------------
    // DAC registers
    // ------------------------------------------------------------
    // DAC A is staged: the upper byte waits until the lower bits arrive,
    // so the output never shows a half-updated 11-bit code.
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            dac_a_hi_q <= 8'h00;
            dac_a_code <= '0;
            dac_b_code <= 8'h00;
            dac_c_code <= 8'h00;
        end
        else if (wr_rise)
        begin
            unique case (wr_addr_q)
                FN_DAC_A_HI:
                    dac_a_hi_q <= wr_data_q;
                FN_DAC_A_LO:
                    dac_a_code <= {dac_a_hi_q, wr_data_q[7:DAC_A_LO_POS]};
                FN_DAC_B:
                    dac_b_code <= wr_data_q;
                FN_DAC_C:
                    dac_c_code <= wr_data_q;
                default:
                    dac_b_code <= dac_b_code;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Conversion start
    // ------------------------------------------------------------
    // A start while busy is low is dropped; the host is not meant to do it.
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            start_q <= 1'b0;
            chan_q <= DTS_CH_IN1;
        end
        else
        begin
            start_q <= 1'b0;
            if (wr_rise && wr_addr_q[2] && wr_addr_q != FN_CONTROL && sq.busy_n)
            begin
                start_q <= 1'b1;
                chan_q <= chan_of(wr_addr_q);
            end
        end
    end

    assign sq.start = start_q;
    assign sq.single_mode = ctl_q[BIT_SINGLE];
    assign sq.first_b = ctl_q[BIT_FIRST_B];

    dts_sequencer u_seq (
        .core_clk(core_clk),
        .nrst(nrst),
        .sq(sq.seq)
    );

    // ------------------------------------------------------------
    // Status and analog steering
    // ------------------------------------------------------------
    assign busy_n = sq.busy_n;
    assign osc_en = sq.osc_en;
    assign th_hold = sq.hold;
    assign adc_side_b = sq.side_b;
    assign adc_active = sq.converting;

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            adc_chan <= DTS_CH_IN1;
            adc_range_half <= 1'b0;
            input_range_half <= 4'h0;
        end
        else
        begin
            adc_chan <= chan_q;
            adc_range_half <= range_of(ctl_q, sq.side_b, chan_q);
            input_range_half <= ctl_q[3:0];
        end
    end

    // ------------------------------------------------------------
    // Result latches
    // ------------------------------------------------------------
    // The code is taken on the strobe that ends each conversion; the last
    // one falls in the same cycle that busy rises, so a read after busy high sees it.
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            latch_a_q <= 8'h00;
            latch_b_q <= 8'h00;
        end
        else if (sq.result_strobe)
        begin
            if (sq.side_b)
                latch_b_q <= adc_code;
            else
                latch_a_q <= adc_code;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Level driven: no strobe edge is needed, the selected latch tracks
    // the address bit one clock later while select and read stay low.
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            data_out <= 8'h00;
            data_oe_n <= 1'b1;
        end
        else
        begin
            data_oe_n <= !(!cs_n && !rd_n);
            data_out <= func_addr[0] ? latch_b_q : latch_a_q;
        end
    end
endmodule : dts_converter_ctrl

// >>> logic/dts_pkg.sv
// Constants and types shared by the track/hold converter sequencer
// Operation
// - Control bit four low selects double conversion, high selects single.
// - Double mode holds both sides together, converts both, busy until both done.
// - Single mode holds both sides, converts one, busy ends after it.
// - Control bit five picks first side: zero A, one B.
// - Control bits zero to three set half range per input A1, A2, B1, B2.
// - Chip select and read low drive latch A when address bit0 low, else B.
// - Read path is level driven; output follows latch select bit directly; the code registers it, so it follows one clock later.
// - Latch A takes every A-side result, latch B every B-side result.
// - Three address bits of each write select its function.
// - Bus data is captured only on the rising edge of write strobe; the code writes the address and data it last sampled while the strobe was low.
// - DAC data is left justified; 11-bit word split upper byte, lower three.
// - Start edge starts oscillator, acquisition, and drives busy low.
// - Acquisition lasts about 1.5 us before both track/holds hold.
// - First conversion ends within 3.6 us of start; single mode releases busy.
// - Second conversion follows at once, at most 2.4 us more, then busy releases.
// - Oscillator stops at the end of every sequence.
// - Start write address selects input one, input two or bias per side.
// - Write decode: DAC A hi, DAC A lo, DAC B, DAC C, starts, control.
package dts_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int ACQ_TIME_NS = 1500;
    localparam int FIRST_CONV_NS = 3600;
    localparam int SECOND_CONV_NS = 2400;
    // Least time rounds up, longest times round down
    localparam int ACQ_CYC = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FIRST_CYC = FIRST_CONV_NS / CLK_PERIOD_NS;
    localparam int SECOND_CYC = SECOND_CONV_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 9;

    // ------------------------------------------------------------
    // Write function codes and field positions
    // ------------------------------------------------------------
    localparam logic [2:0] FN_DAC_A_HI = 3'h0;
    localparam logic [2:0] FN_DAC_A_LO = 3'h1;
    localparam logic [2:0] FN_DAC_B = 3'h2;
    localparam logic [2:0] FN_DAC_C = 3'h3;
    localparam logic [2:0] FN_START_IN1 = 3'h4;
    localparam logic [2:0] FN_START_IN2 = 3'h5;
    localparam logic [2:0] FN_START_BIAS = 3'h6;
    localparam logic [2:0] FN_CONTROL = 3'h7;
    localparam int CTL_W = 6;
    localparam int BIT_SINGLE = 4;
    localparam int BIT_FIRST_B = 5;
    localparam logic [5:0] CTL_RESET = 6'h00;
    localparam int DAC_A_W = 11;
    localparam int DAC_A_LO_POS = 5;

    // Converted signal on a side
    typedef enum logic [1:0] {DTS_CH_IN1, DTS_CH_IN2, DTS_CH_BIAS} dts_chan_t;
endpackage : dts_pkg

// >>> logic/dts_seq_if.sv
// Carrier between the bus front end and the conversion sequencer
interface dts_seq_if;
    import dts_pkg::*;
    logic start;
    logic single_mode;
    logic first_b;
    logic busy_n;
    logic hold;
    logic osc_en;
    logic side_b;
    logic converting;
    logic result_strobe;

    modport front (output start, output single_mode, output first_b,
                   input busy_n, input hold, input osc_en, input side_b,
                   input converting, input result_strobe);
    modport seq (input start, input single_mode, input first_b,
                 output busy_n, output hold, output osc_en, output side_b,
                 output converting, output result_strobe);
endinterface : dts_seq_if

// >>> logic/dts_sequencer.sv
// Acquisition and conversion timing for one start of a sequence
module dts_sequencer
    import dts_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    dts_seq_if.seq sq
);
    typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV1, ST_CONV2} dts_state_t;

    localparam logic [CNT_W-1:0] ACQ_LAST = CNT_W'(ACQ_CYC - 1);
    localparam logic [CNT_W-1:0] FIRST_LAST = CNT_W'(FIRST_CYC - 1);
    localparam logic [CNT_W-1:0] SECOND_LAST = CNT_W'(SECOND_CYC - 1);
    localparam logic [CNT_W-1:0] FIRST_PRE = CNT_W'(FIRST_CYC - 2);
    localparam logic [CNT_W-1:0] SECOND_PRE = CNT_W'(SECOND_CYC - 2);

    dts_state_t state_q;
    logic [CNT_W-1:0] cnt_q;
    logic single_q;
    logic first_b_q;

    // ------------------------------------------------------------
    // Sequence state; counter measured from the start edge, restarted when the first conversion ends
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            single_q <= 1'b0;
            first_b_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_q + CNT_W'(1);
            unique case (state_q)
                ST_IDLE:
                begin
                    cnt_q <= '0;
                    if (sq.start)
                    begin
                        state_q <= ST_ACQ;
                        single_q <= sq.single_mode;
                        first_b_q <= sq.first_b;
                    end
                end
                ST_ACQ:
                    if (cnt_q == ACQ_LAST)
                        state_q <= ST_CONV1;
                ST_CONV1:
                    if (cnt_q == FIRST_LAST)
                    begin
                        cnt_q <= '0;
                        // Single mode ignores the other held voltage
                        state_q <= single_q ? ST_IDLE : ST_CONV2;
                    end
                ST_CONV2:
                    if (cnt_q == SECOND_LAST)
                        state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registered status toward the pins
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            sq.busy_n <= 1'b1;
            sq.osc_en <= 1'b0;
            sq.hold <= 1'b0;
            sq.side_b <= 1'b0;
            sq.converting <= 1'b0;
            sq.result_strobe <= 1'b0;
        end
        else
        begin
            sq.result_strobe <= 1'b0;
            // Strobe one cycle early: the latch then samples code and side
            // on the edge that ends the conversion, before either moves on
            if ((state_q == ST_CONV1 && cnt_q == FIRST_PRE)
                || (state_q == ST_CONV2 && cnt_q == SECOND_PRE))
                sq.result_strobe <= 1'b1;
            if (state_q == ST_IDLE && sq.start)
            begin
                sq.busy_n <= 1'b0;
                sq.osc_en <= 1'b1;
                sq.side_b <= sq.first_b;
            end
            if (state_q == ST_ACQ && cnt_q == ACQ_LAST)
            begin
                sq.hold <= 1'b1;
                sq.converting <= 1'b1;
            end
            if (state_q == ST_CONV1 && cnt_q == FIRST_LAST)
            begin
                if (single_q)
                begin
                    sq.busy_n <= 1'b1;
                    sq.osc_en <= 1'b0;
                    sq.hold <= 1'b0;
                    sq.converting <= 1'b0;
                end
                else
                    sq.side_b <= !first_b_q;
            end
            if (state_q == ST_CONV2 && cnt_q == SECOND_LAST)
            begin
                sq.busy_n <= 1'b1;
                sq.osc_en <= 1'b0;
                sq.hold <= 1'b0;
                sq.converting <= 1'b0;
            end
        end
    end
endmodule : dts_sequencer

// >>> tb/dts_adc_model.sv
// Behavioural converter core that answers the sequencer
module dts_adc_model
    import dts_pkg::*;
(
    input wire logic core_clk,
    input wire logic adc_active,
    input wire logic adc_side_b,
    input wire dts_chan_t adc_chan,
    input wire logic adc_range_half,
    output logic [7:0] adc_code
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] idle_q = 8'h00;

    // Code encodes side, signal and range so each latch can be traced
    always_comb adc_code = adc_active ?
        {adc_side_b, 1'b0, adc_chan, adc_range_half, 3'h6} : idle_q;
    // Outside conversions the code wanders, so stale samples never match
    always @(posedge core_clk) idle_q <= idle_q + 8'h3b;
endmodule : dts_adc_model

// >>> tb/dts_conv_asserts.sv
// Concurrent checks on the converter control block ports
module dts_conv_asserts
    import dts_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic data_oe_n,
    input wire logic busy_n,
    input wire logic osc_en,
    input wire logic th_hold,
    input wire logic adc_side_b,
    input wire dts_chan_t adc_chan,
    input wire logic adc_range_half,
    input wire logic adc_active,
    input wire logic [3:0] input_range_half,
    input wire logic [DAC_A_W-1:0] dac_a_code,
    input wire logic [7:0] dac_b_code,
    input wire logic [7:0] dac_c_code
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Read path
    // ----------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    // Level driven, so a held select keeps the bus driven
    chk_read_drive: assert property ((!cs_n && !rd_n) |=> !data_oe_n)
        else $error("bus not driven during read");
    chk_read_release: assert property ((cs_n || rd_n) |=> data_oe_n)
        else $error("bus driven outside read");

    // ----------------------------------------
    // Conversion sequence
    // ----------------------------------------
    chk_osc_busy: assert property (osc_en == !busy_n)
        else $error("oscillator and busy disagree");
    chk_hold_acq: assert property ($fell(busy_n) |-> ##150 $rose(th_hold))
        else $error("hold not at end of acquisition");
    // Edges since busy fell; a plain delay this long is slow to unroll
    logic busy_n_q;
    logic [9:0] since_start_q;
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            busy_n_q <= 1'b1;
            since_start_q <= 10'h000;
        end
        else
        begin
            busy_n_q <= busy_n;
            if (busy_n_q && !busy_n)
                since_start_q <= 10'h001;
            else if (since_start_q != 10'h000 && since_start_q != 10'h3ff)
                since_start_q <= since_start_q + 10'h001;
        end
    end
    // Side flips for double, busy releases for single
    chk_first_end: assert property ((since_start_q == 10'h168) |->
        (busy_n || adc_side_b != $past(adc_side_b)))
        else $error("first conversion end misplaced");
    chk_busy_len: assert property ($fell(busy_n) |-> ##[360:600] $rose(busy_n))
        else $error("busy span out of bounds");
    chk_active_hold: assert property (adc_active == th_hold)
        else $error("converter active outside hold");
    chk_hold_busy: assert property (th_hold |-> !busy_n && osc_en)
        else $error("hold without busy");
    chk_bias_range: assert property ((adc_active && adc_chan == DTS_CH_BIAS)
        |-> !adc_range_half)
        else $error("bias conversion with half range");
    // Registers only move after a write strobe rise; range bits lag one edge more
    chk_wr_quiet: assert property (($past(wr_n) && $past(wr_n, 2) && $past(wr_n, 3)) |->
        $stable({dac_a_code, dac_b_code, dac_c_code, input_range_half}))
        else $error("register changed without write edge");
endmodule : dts_conv_asserts

bind dts_converter_ctrl dts_conv_asserts i_chk (
    .core_clk(core_clk), .nrst(nrst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .data_oe_n(data_oe_n), .busy_n(busy_n), .osc_en(osc_en), .th_hold(th_hold),
    .adc_side_b(adc_side_b), .adc_chan(adc_chan), .adc_range_half(adc_range_half),
    .adc_active(adc_active), .input_range_half(input_range_half),
    .dac_a_code(dac_a_code), .dac_b_code(dac_b_code), .dac_c_code(dac_c_code)
);

// >>> tb/dual_track_hold_adc_sequencer_test.sv
// Self-checking bench for the converter control block
module dual_track_hold_adc_sequencer_test
    import dts_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, nrst = 1'b0, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
    logic [2:0] func_addr = 3'h0;
    logic [7:0] data_in = 8'h00, data_out, adc_code, dac_b_code, dac_c_code, la = 8'h00, lb = 8'h00;
    logic data_oe_n, busy_n, osc_en, th_hold, adc_side_b, adc_range_half, adc_active;
    logic first_side;
    dts_chan_t adc_chan;
    logic [3:0] input_range_half;
    logic [DAC_A_W-1:0] dac_a_code;
    int errors = 0, checks = 0, cyc = 0, low_n = 0;

    dts_converter_ctrl i_dut (.core_clk(core_clk), .nrst(nrst), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .func_addr(func_addr), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n), .busy_n(busy_n), .osc_en(osc_en), .th_hold(th_hold),
        .adc_side_b(adc_side_b), .adc_chan(adc_chan), .adc_range_half(adc_range_half),
        .adc_active(adc_active), .adc_code(adc_code), .input_range_half(input_range_half),
        .dac_a_code(dac_a_code), .dac_b_code(dac_b_code), .dac_c_code(dac_c_code));
    dts_adc_model i_adc (.core_clk(core_clk), .adc_active(adc_active),
        .adc_side_b(adc_side_b), .adc_chan(adc_chan), .adc_range_half(adc_range_half),
        .adc_code(adc_code));

    // ----------------------------------------
    // Clock, busy monitor, hang guard
    // ----------------------------------------
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk)
        if (busy_n === 1'b0)
            low_n++;
    // Side converted first is the one current when hold starts
    always @(posedge th_hold) first_side = adc_side_b;
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            errors++;
            stop_test;
        end
    end

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    // Data is taken at the write strobe rise; select held one edge past it
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        func_addr <= a;
        data_in <= d;
        @(posedge core_clk);
        wr_n <= 1'b1;
        @(posedge core_clk);
        cs_n <= 1'b1;
        data_in <= ~d;
        repeat (2) @(posedge core_clk);
        #1;
    endtask : wr

    // Reads both latches by moving only the select bit under a held strobe
    task rd2;
        @(posedge core_clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        func_addr <= 3'h0;
        @(posedge core_clk) #1;
        check(16'({data_oe_n, data_out}), 16'(la), "latch a");
        @(posedge core_clk);
        func_addr <= 3'h1;
        @(posedge core_clk) #1;
        check(16'({data_oe_n, data_out}), 16'(lb), "latch b");
        @(posedge core_clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        @(posedge core_clk) #1;
        check(16'(data_oe_n), 16'h1, "bus release");
    endtask : rd2

    function automatic logic [7:0] exp_code(input logic s, input logic [1:0] ch,
                                            input logic [3:0] r);
        logic h;
        h = (ch == 2'h2) ? 1'b0 : r[{s, ch[0]}];
        return {s, 1'b0, ch, h, 3'h6};
    endfunction : exp_code

    // One sequence: control load, start, span, order and latch contents
    task conv(input logic [5:0] ctl, input logic [2:0] a, input bit refuse);
        logic [1:0] ch;
        ch = 2'(a - 3'h4);
        wr(3'h7, {2'h3, ctl});
        check(16'(input_range_half), 16'(ctl[3:0]), "range bits");
        low_n = 0;
        // Cleared so a sequence that never holds cannot pass on a stale side
        first_side = 1'bx;
        wr(a, 8'h00);
        if (refuse)
            wr(3'h5, 8'h00);
        repeat (800)
            if (busy_n !== 1'b1)
                @(posedge core_clk) #1;
        check(16'(low_n), ctl[4] ? 16'd360 : 16'd600, "busy span");
        check(16'(first_side), 16'(ctl[5]), "first side");
        if (!ctl[4] || !ctl[5])
            la = exp_code(1'b0, ch, ctl[3:0]);
        if (!ctl[4] || ctl[5])
            lb = exp_code(1'b1, ch, ctl[3:0]);
        rd2;
    endtask : conv

    task stop_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk) #1;
        check(16'({data_oe_n, busy_n, input_range_half}), 16'h30, "reset state");
        wr(3'h0, 8'ha5);
        check(16'(dac_a_code), 16'h0, "dac a held");
        wr(3'h1, 8'he0);
        check(16'(dac_a_code), 16'h52f, "dac a load");
        wr(3'h2, 8'h5c);
        check(16'(dac_b_code), 16'h5c, "dac b load");
        wr(3'h3, 8'hc3);
        check(16'(dac_c_code), 16'hc3, "dac c load");
        conv(6'h15, 3'h4, 1'b0);
        conv(6'h3a, 3'h5, 1'b0);
        conv(6'h05, 3'h6, 1'b0);
        conv(6'h2a, 3'h4, 1'b1);
        stop_test;
    end
endmodule : dual_track_hold_adc_sequencer_test
